// >>> include/sta_pkg.sv
// constants and types for the star tracker acquisition logic
package sta_pkg;
   // clock rate and hold time
   localparam int unsigned CLK_HZ      = 25_000_000;
   localparam int unsigned HOLD_S      = 7;
   localparam int unsigned HOLD_CYCLES = CLK_HZ * HOLD_S;
   localparam int unsigned FLYBACK_MS  = 10;
   localparam int unsigned FLYBACK_CYCLES = CLK_HZ / 1000 * FLYBACK_MS;
   localparam int unsigned CNT_W       = 28;

   // intensity scale: nominal target intensity is 100 counts
   localparam int unsigned INT_W       = 12;
   localparam logic [11:0] NOMINAL     = 12'h0064;
   // gate levels in hundredths of nominal
   localparam logic [11:0] LOW1_PCT    = 12'h0046;
   localparam logic [11:0] LOW2_PCT    = 12'h0023;
   localparam logic [11:0] LOW3_PCT    = 12'h0014;
   localparam logic [11:0] HIGH_PCT    = 12'h015E;

   // cone settings
   localparam logic [2:0] CONE_COUNT   = 3'h5;
   localparam logic [2:0] CONE_RESET   = 3'h2;

   // low gate level codes
   localparam logic [1:0] GATE_L1      = 2'h1;
   localparam logic [1:0] GATE_L2      = 2'h2;
   localparam logic [1:0] GATE_L3      = 2'h3;

   // clock bias selection driven to the deflection circuit
   typedef enum logic [1:0] {
      BIAS_SEARCH   = 2'b00,
      BIAS_TRACK    = 2'b01,
      BIAS_FLYBACK  = 2'b10,
      BIAS_OVERRIDE = 2'b11
   } sta_bias_e;

   // acquisition sequencer
   typedef enum logic [2:0] {
      ST_SEARCH  = 3'b000,
      ST_TRACK   = 3'b001,
      ST_FLYBACK = 3'b010,
      ST_SWEEP   = 3'b011,
      ST_BRIGHT  = 3'b100
   } sta_state_e;
endpackage

// >>> verilog/sta_acq.sv
// star tracker clock bias, cone step, gating and acquired-signal logic
//
// Operation
// - flyback or override bias beats tracking and search bias.
// - search bias applies only with no hard bias and no tracking.
// - cone position takes one of five discrete settings only.
// - with a star tracked and no hard bias, tracking bias governs clock.
// - roll search applies search bias, field at plus clock edge.
// - roll override drives field to plus edge, starting roll search.
// - flyback bias holds field against the minus clock edge.
// - flyback-and-sweep is flyback bias, then search bias sweeping plus-ward.
// - losing the tracked target starts flyback-and-sweep automatically.
// - before acquisition, target needs intensity above low and below high gate.
// - low gate levels 1..3 are 0.7, 0.35, 0.2 nominal; level 1 default.
// - high gate 3.5 nominal before acquisition, removed once acquired.
// - once acquired, signal holds while intensity stays above low gate.
// - after falling below low gate, acquired holds 7 s through flyback and sweep.
// - no reacquisition within 7 s drops acquired; roll search follows.
// - bright object after acquisition is tracked, then flyback-and-sweep.
// - with no star in field, roll error reflects fixed search bias.
// - tracking demodulator enabled only after target declared acquired.
`timescale 1ns/100ps
module sta_acq (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        srst,
   // star intensity from the analog chain, same clock domain
   input  wire logic [11:0] star_intensity,
   input  wire logic        star_in_field,
   // commands from the attitude control unit
   input  wire logic        roll_override_req,
   input  wire logic [1:0]  low_gate_sel,
   input  wire logic        cone_step_up,
   input  wire logic        cone_step_down,
   // clock bias and cone control
   output logic [1:0]       clock_bias_sel,
   output logic             flyback_bias_on,
   output logic             override_bias_on,
   output logic             search_bias_on,
   output logic             demod_enable,
   output logic             roll_error_from_search,
   output logic [2:0]       cone_position,
   // status to the attitude control unit
   output logic             star_acquired,
   output logic             high_gate_enabled,
   output logic [1:0]       low_gate_level
);

   // gate threshold in intensity counts from hundredths of nominal
   function automatic logic [11:0] gate_counts(input logic [11:0] pct);
      logic [23:0] prod;
      prod = pct * sta_pkg::NOMINAL;
      return 12'(prod / 24'd100);
   endfunction

   // one step of the flyback and hold cycle counters
   function automatic logic [27:0] count_up(input logic [27:0] cnt);
      return cnt + 28'h000_0001;
   endfunction

   // low gate threshold for a level code, unknown codes fall back to level 1
   function automatic logic [11:0] low_gate_threshold(input logic [1:0] level);
      if (level == sta_pkg::GATE_L2) begin
         return gate_counts(sta_pkg::LOW2_PCT);
      end else if (level == sta_pkg::GATE_L3) begin
         return gate_counts(sta_pkg::LOW3_PCT);
      end
      return gate_counts(sta_pkg::LOW1_PCT);
   endfunction

   // tracking states, where the demodulator steers the field
   function automatic logic is_tracking(input sta_pkg::sta_state_e st);
      return (st == sta_pkg::ST_TRACK) || (st == sta_pkg::ST_BRIGHT);
   endfunction

   // clock bias by priority: override, flyback, tracking, then search
   function automatic sta_pkg::sta_bias_e pick_bias(input logic override_on,
                                                     input logic flyback_on,
                                                     input logic track_on);
      if (override_on) begin
         return sta_pkg::BIAS_OVERRIDE;
      end else if (flyback_on) begin
         return sta_pkg::BIAS_FLYBACK;
      end else if (track_on) begin
         return sta_pkg::BIAS_TRACK;
      end
      return sta_pkg::BIAS_SEARCH;
   endfunction

   // next cone setting; steps stop at both ends, opposing requests cancel
   function automatic logic [2:0] cone_step(input logic [2:0] pos,
                                            input logic       up,
                                            input logic       down);
      if (up && !down && pos < sta_pkg::CONE_COUNT - 3'h1) begin
         return pos + 3'h1;
      end else if (down && !up && pos != 3'h0) begin
         return pos - 3'h1;
      end
      return pos;
   endfunction

   // sequencer state and timers
   sta_pkg::sta_state_e state;
   sta_pkg::sta_state_e next_state;
   logic [27:0]         hold_cnt;
   logic [27:0]         next_hold_cnt;
   logic [27:0]         fly_cnt;
   logic [27:0]         next_fly_cnt;
   logic                hold_expired;
   logic                fly_done;

   // gate comparison
   logic [11:0]         low_thr;
   logic                above_low;
   logic                below_high;
   logic                in_gate;
   logic                target_lost;
   logic                bright_present;

   // next values of the registered outputs
   logic [1:0]          next_low_gate_level;
   logic [2:0]          next_cone_position;
   logic                next_star_acquired;
   logic                next_high_gate_enabled;
   logic [1:0]          next_clock_bias_sel;
   logic                next_flyback_bias_on;
   logic                next_override_bias_on;
   logic                next_search_bias_on;
   logic                next_demod_enable;
   logic                next_roll_error_from_search;

   always_comb begin
      low_thr        = low_gate_threshold(low_gate_level);
      above_low      = star_in_field && (star_intensity > low_thr);
      below_high     = star_intensity < gate_counts(sta_pkg::HIGH_PCT);
      in_gate        = above_low && below_high;
      target_lost    = !above_low;
      bright_present = !below_high;
   end

   // terminal counts of the flyback and hold timers
   always_comb begin
      // the hold runs from the first flyback cycle until the star is back or HOLD_CYCLES have passed
      hold_expired = (hold_cnt >= 28'(sta_pkg::HOLD_CYCLES - 1));
      fly_done     = (fly_cnt >= 28'(sta_pkg::FLYBACK_CYCLES - 1));
   end

   // low gate selection, code 0 falls back to level 1
   always_comb begin
      next_low_gate_level = low_gate_sel;
      if (low_gate_sel == 2'h0) begin
         next_low_gate_level = sta_pkg::GATE_L1;
      end
   end

   // sequencer, hold timer and status
   always_comb begin
      next_state             = state;
      next_hold_cnt          = hold_cnt;
      next_fly_cnt           = fly_cnt;
      next_star_acquired     = star_acquired;
      next_high_gate_enabled = high_gate_enabled;
      case (state)
         // roll search: wait for a star inside both gates
         sta_pkg::ST_SEARCH: begin
            next_star_acquired     = 1'b0;
            next_high_gate_enabled = 1'b1;
            if (in_gate && !roll_override_req) begin
               next_state             = sta_pkg::ST_TRACK;
               next_star_acquired     = 1'b1;
               next_high_gate_enabled = 1'b0;
            end
         end
         // tracking: loss starts flyback, a bright object is followed
         sta_pkg::ST_TRACK: begin
            next_hold_cnt = '0;
            if (target_lost) begin
               next_state   = sta_pkg::ST_FLYBACK;
               next_fly_cnt = '0;
            end else if (bright_present) begin
               next_state = sta_pkg::ST_BRIGHT;
            end
         end
         // bright object followed with the high gate removed
         sta_pkg::ST_BRIGHT: begin
            next_hold_cnt = '0;
            if (target_lost) begin
               next_state   = sta_pkg::ST_FLYBACK;
               next_fly_cnt = '0;
            end else if (!bright_present) begin
               next_state = sta_pkg::ST_TRACK;
            end
         end
         // flyback: field held at the minus edge, hold timer running
         sta_pkg::ST_FLYBACK: begin
            next_hold_cnt = count_up(hold_cnt);
            next_fly_cnt  = count_up(fly_cnt);
            if (hold_expired) begin
               next_state             = sta_pkg::ST_SEARCH;
               next_star_acquired     = 1'b0;
               next_high_gate_enabled = 1'b1;
            end else if (fly_done) begin
               next_state = sta_pkg::ST_SWEEP;
            end
         end
         // sweep: search bias moves the field back toward the plus edge
         sta_pkg::ST_SWEEP: begin
            next_hold_cnt = count_up(hold_cnt);
            if (above_low) begin
               next_state    = sta_pkg::ST_TRACK;
               next_hold_cnt = '0;
            end else if (hold_expired) begin
               next_state             = sta_pkg::ST_SEARCH;
               next_star_acquired     = 1'b0;
               next_high_gate_enabled = 1'b1;
            end
         end
         default: begin
            next_state = sta_pkg::ST_SEARCH;
         end
      endcase
      // override breaks lock at once and restarts roll search
      if (roll_override_req) begin
         next_state             = sta_pkg::ST_SEARCH;
         next_star_acquired     = 1'b0;
         next_high_gate_enabled = 1'b1;
      end
   end

   // clock bias priority
   always_comb begin
      next_flyback_bias_on  = (next_state == sta_pkg::ST_FLYBACK);
      next_override_bias_on = roll_override_req;
      next_demod_enable     = next_star_acquired &&
                              is_tracking(next_state);
      next_clock_bias_sel   = pick_bias(next_override_bias_on, next_flyback_bias_on,
                                        next_demod_enable);
      next_search_bias_on = (next_clock_bias_sel == sta_pkg::BIAS_SEARCH);
      next_roll_error_from_search = !star_in_field || next_search_bias_on;
   end

   // cone stepping among the five settings
   always_comb begin
      next_cone_position = cone_step(cone_position, cone_step_up,
                                     cone_step_down);
   end

   // low gate level register
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         low_gate_level <= sta_pkg::GATE_L1;
      end else begin
         low_gate_level <= next_low_gate_level;
      end
   end

   // sequencer state and timers
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         state    <= sta_pkg::ST_SEARCH;
         hold_cnt <= '0;
         fly_cnt  <= '0;
      end else begin
         state    <= next_state;
         hold_cnt <= next_hold_cnt;
         fly_cnt  <= next_fly_cnt;
      end
   end

   // acquisition status
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         high_gate_enabled <= 1'b1;
         star_acquired     <= 1'b0;
      end else begin
         high_gate_enabled <= next_high_gate_enabled;
         star_acquired     <= next_star_acquired;
      end
   end

   // clock bias registers
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         flyback_bias_on        <= 1'b0;
         override_bias_on       <= 1'b0;
         search_bias_on         <= 1'b1;
         clock_bias_sel         <= sta_pkg::BIAS_SEARCH;
         demod_enable           <= 1'b0;
         roll_error_from_search <= 1'b1;
      end else begin
         flyback_bias_on        <= next_flyback_bias_on;
         override_bias_on       <= next_override_bias_on;
         search_bias_on         <= next_search_bias_on;
         clock_bias_sel         <= next_clock_bias_sel;
         demod_enable           <= next_demod_enable;
         roll_error_from_search <= next_roll_error_from_search;
      end
   end

   // cone position register
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         cone_position <= sta_pkg::CONE_RESET;
      end else begin
         cone_position <= next_cone_position;
      end
   end

endmodule

// >>> verif/sta_acq_asserts.sv
// port-level checks on the star tracker acquisition logic
`timescale 1ns/100ps
module sta_acq_asserts (
   // clock, reset and inputs
   input wire logic        ref_clk,
   input wire logic        srst,
   input wire logic [11:0] star_intensity,
   input wire logic        star_in_field,
   input wire logic        roll_override_req,
   input wire logic [1:0]  low_gate_sel,
   input wire logic        cone_step_up,
   input wire logic        cone_step_down,
   // outputs
   input wire logic [1:0]  clock_bias_sel,
   input wire logic        flyback_bias_on,
   input wire logic        override_bias_on,
   input wire logic        search_bias_on,
   input wire logic        demod_enable,
   input wire logic        roll_error_from_search,
   input wire logic [2:0]  cone_position,
   input wire logic        star_acquired,
   input wire logic        high_gate_enabled,
   input wire logic [1:0]  low_gate_level
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);
   a_override_wins: assert property (roll_override_req |=>
      clock_bias_sel == sta_pkg::BIAS_OVERRIDE && override_bias_on && !star_acquired)
      else $error("override bias not applied");
   a_search_lowest: assert property (clock_bias_sel == sta_pkg::BIAS_SEARCH |->
      search_bias_on && roll_error_from_search && !flyback_bias_on && !override_bias_on)
      else $error("search bias with a higher bias active");
   a_flyback_minus: assert property (flyback_bias_on |->
      clock_bias_sel == sta_pkg::BIAS_FLYBACK) else $error("flyback bias not selected");
   a_cone_range: assert property (cone_position <= 3'h4)
      else $error("cone position out of range");
   a_cone_step: assert property (cone_step_up && !cone_step_down && cone_position < 3'h4 |=>
      cone_position == $past(cone_position) + 3'h1) else $error("cone step lost");
   a_demod_acquired: assert property (demod_enable |-> star_acquired)
      else $error("demodulator on without acquisition");
   a_high_removed: assert property (star_acquired |-> !high_gate_enabled)
      else $error("high gate still on after acquisition");
   a_gate_window: assert property (!star_acquired && !roll_override_req && !override_bias_on
      && star_in_field && low_gate_level == sta_pkg::GATE_L1 && low_gate_sel == sta_pkg::GATE_L1
      && star_intensity > sta_pkg::LOW1_PCT && star_intensity < sta_pkg::HIGH_PCT
      |=> star_acquired) else $error("star inside gates not acquired");
   a_loss_flyback: assert property (star_acquired && clock_bias_sel == sta_pkg::BIAS_TRACK
      && !roll_override_req && low_gate_level == sta_pkg::GATE_L1
      && low_gate_sel == sta_pkg::GATE_L1 && star_intensity <= sta_pkg::LOW1_PCT
      |=> flyback_bias_on && star_acquired) else $error("no flyback on target loss");
   a_reset_state: assert property (disable iff (1'b0) srst |=> !star_acquired
      && high_gate_enabled && low_gate_level == sta_pkg::GATE_L1 && !flyback_bias_on
      && !override_bias_on) else $error("wrong state after reset");
endmodule

// >>> verif/sta_acu_model.sv
// attitude control unit stand-in: registers bench commands onto the block inputs
`timescale 1ns/100ps
module sta_acu_model (
   // clock and bench commands
   input  wire logic       ref_clk,
   input  wire logic       cmd_break,
   input  wire logic [1:0] cmd_gate,
   input  wire logic       cmd_up,
   input  wire logic       cmd_down,
   // block commands and status
   output logic            roll_override_req,
   output logic [1:0]      low_gate_sel,
   output logic            cone_step_up,
   output logic            cone_step_down,
   input  wire logic       star_acquired,
   output logic            roll_search
);
   initial begin
      roll_override_req = 1'b0;
      low_gate_sel = 2'h1;
      cone_step_up = 1'b0;
      cone_step_down = 1'b0;
      roll_search = 1'b1;
   end
   always @(posedge ref_clk) begin
      roll_override_req <= cmd_break;
      low_gate_sel <= cmd_gate;
      cone_step_up <= cmd_up;
      cone_step_down <= cmd_down;
      roll_search <= !star_acquired;
   end
endmodule

// >>> verif/star_tracker_acquisition_logic_tb.sv
// self-checking bench for the star tracker acquisition logic
`timescale 1ns/100ps
module star_tracker_acquisition_logic_tb;
   typedef struct {logic [11:0] inten; logic fld; logic [1:0] gate; logic acq;} sta_row_s;
   logic ref_clk = 1'b0, srst = 1'b1, star_in_field = 1'b0, cmd_break = 1'b0;
   logic cmd_up = 1'b0, cmd_down = 1'b0, roll_override_req, cone_step_up, cone_step_down;
   logic [11:0] star_intensity = 12'h0000;
   logic [1:0] cmd_gate = 2'h1, low_gate_sel, clock_bias_sel, low_gate_level;
   logic flyback_bias_on, override_bias_on, search_bias_on, demod_enable, roll_search;
   logic roll_error_from_search, star_acquired, high_gate_enabled;
   logic [2:0] cone_position;
   int err_count = 0;
   int checks = 0;
   sta_row_s rows[10] = '{'{12'h0047, 1, 2'h1, 1}, '{12'h0046, 1, 2'h1, 0},
      '{12'h015D, 1, 2'h1, 1}, '{12'h015E, 1, 2'h1, 0}, '{12'h0024, 1, 2'h2, 1},
      '{12'h0023, 1, 2'h2, 0}, '{12'h0015, 1, 2'h3, 1}, '{12'h0014, 1, 2'h3, 0},
      '{12'h0047, 1, 2'h0, 1}, '{12'h0064, 0, 2'h1, 0}};
   sta_acq sta_acq_i (.*);
   sta_acu_model sta_acu_model_i (.*);
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic do_reset(input int n);
      srst <= 1'b1;
      tick(n);
      srst <= 1'b0;
   endtask
   task automatic report_and_stop;
      if (err_count == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic set_star(input logic [11:0] v, input int n);
      @(posedge ref_clk);
      star_intensity <= v;
      tick(n);
      @(negedge ref_clk);
   endtask
   initial begin
      forever #20 ref_clk = ~ref_clk;
   end
   initial begin
      tick(5000);
      err_count++;
      report_and_stop;
   end
   initial begin
      do_reset(6);
      @(negedge ref_clk);
      chk("acquired", 0, star_acquired);
      chk("high_gate", 1, high_gate_enabled);
      chk("gate_level", 1, low_gate_level);
      chk("bias_sel", sta_pkg::BIAS_SEARCH, clock_bias_sel);
      chk("search_bias", 1, search_bias_on);
      chk("flyback_bias", 0, flyback_bias_on);
      chk("override_bias", 0, override_bias_on);
      chk("roll_err_src", 1, roll_error_from_search);
      foreach (rows[i]) begin
         @(posedge ref_clk);
         cmd_gate <= rows[i].gate;
         star_intensity <= 12'h0000;
         star_in_field <= rows[i].fld;
         do_reset(2);
         tick(2);
         set_star(rows[i].inten, 2);
         chk("row_acquired", rows[i].acq, star_acquired);
         chk("row_gate_level", rows[i].gate == 0 ? 1 : rows[i].gate, low_gate_level);
      end
      @(posedge ref_clk);
      cmd_gate <= 2'h1;
      star_in_field <= 1'b1;
      do_reset(2);
      set_star(12'h0064, 3);
      chk("track_sel", sta_pkg::BIAS_TRACK, clock_bias_sel);
      chk("demod", 1, demod_enable);
      chk("high_gate", 0, high_gate_enabled);
      chk("track_roll_err", 0, roll_error_from_search);
      chk("track_roll_search", 0, roll_search);
      set_star(12'h0190, 3);
      chk("bright_acq", 1, star_acquired);
      chk("bright_sel", sta_pkg::BIAS_TRACK, clock_bias_sel);
      set_star(12'h0000, 3);
      chk("loss_sel", sta_pkg::BIAS_FLYBACK, clock_bias_sel);
      chk("loss_acq", 1, star_acquired);
      chk("loss_flyback", 1, flyback_bias_on);
      @(posedge ref_clk);
      cmd_break <= 1'b1;
      set_star(12'h0000, 3);
      chk("override_sel", sta_pkg::BIAS_OVERRIDE, clock_bias_sel);
      chk("override_acq", 0, star_acquired);
      chk("override_bias", 1, override_bias_on);
      chk("override_roll_search", 1, roll_search);
      chk("override_high_gate", 1, high_gate_enabled);
      @(posedge ref_clk);
      cmd_break <= 1'b0;
      cmd_up <= 1'b1;
      tick(6);
      cmd_up <= 1'b0;
      set_star(12'h0000, 3);
      chk("cone_top", 4, cone_position);
      @(posedge ref_clk);
      cmd_down <= 1'b1;
      tick(6);
      cmd_down <= 1'b0;
      set_star(12'h0000, 3);
      chk("cone_bottom", 0, cone_position);
      report_and_stop;
   end
endmodule
bind sta_acq sta_acq_asserts sta_acq_asserts_i (.*);
